// ### core/ppdc_map.vh
// constants for the pipelined presettable down-counter
// assumes inclusion by both design files under core/
`ifndef PPDC_MAP_VH
`define PPDC_MAP_VH

`define PPDC_SECTION_BITS 2
`define PPDC_DEF_SECTIONS 20
`define PPDC_MAX_SECTIONS 20
`define PPDC_DIBIT_ZERO 2'h0
`define PPDC_DIBIT_ONE 2'h1
`define PPDC_DIBIT_STEP 2'h1
`define PPDC_LOAD_ACTIVE 1'b0
`define PPDC_LOAD_IDLE 1'b1
`define PPDC_RESET_COUNT 2'h0

`endif

// ### core/ppdc_section.v
// one two-bit section of the pipelined down-counter
// assumes a single clock; load_n comes from the lsb pipeline flip-flop
`include "ppdc_map.vh"

module ppdc_section #(
    parameter TC_PIPE = 1
) (
    input wire clk,                                  // counting clock
    input wire rst,                                  // synchronous reset, high
    input wire carry_in,                             // count enable for this dibit
    input wire load_n,                               // parallel load, active low
    input wire [`PPDC_SECTION_BITS-1:0] preset_bits, // preset data for this dibit
    input wire tc_in,                                // terminal count from the section above
    output reg [`PPDC_SECTION_BITS-1:0] count_bits,  // dibit state
    output reg carry_out,                            // pipelined carry to the section above
    output wire tc_out                               // terminal count toward the section below
);

    function is_zero;
        input [`PPDC_SECTION_BITS-1:0] v;
        begin
            is_zero = (v == `PPDC_DIBIT_ZERO);
        end
    endfunction

    // load term in the gate drops tc one clock after load
    wire tc_now = is_zero(count_bits) & tc_in & (load_n == `PPDC_LOAD_IDLE); // [R02] [R06]

    always @(posedge clk) begin
        if (rst) begin
            count_bits <= `PPDC_RESET_COUNT;
            carry_out <= 1'b0;
        end else if (load_n == `PPDC_LOAD_ACTIVE) begin
            count_bits <= preset_bits;                                   // [R01] [R13] [R09]
            carry_out <= 1'b0;
        end else begin
            if (carry_in) begin
                count_bits <= count_bits - `PPDC_DIBIT_STEP;             // [R01]
            end
            carry_out <= carry_in & is_zero(count_bits);                 // [R03] [R04]
        end
    end

    generate
        if (TC_PIPE != 0) begin : g_pipe
            reg tc_stage;
            always @(posedge clk) begin
                if (rst) begin
                    tc_stage <= 1'b0;
                end else begin
                    tc_stage <= tc_now;                                  // [R05] [R06]
                end
            end
            assign tc_out = tc_stage;
        end else begin : g_comb
            // shorter preset limit, longer combinational path
            assign tc_out = tc_now;                                      // [R12]
        end
    endgenerate

endmodule // ppdc_section

// ### core/ppdc_counter.v
// long presettable binary down-counter built from pipelined two-bit sections
// assumes one clock, synchronous inputs; preset held stable while running
`include "ppdc_map.vh"

// Operation
// [R01] each dibit is a presettable down-counter with enable, load and two data bits
// [R02] a dibit reports terminal count when zero and the dibit above reports it
// [R03] carry flop sets when enabled and dibit is 00; feeds next dibit's enable
// [R04] carry flop holds exactly one clock then clears
// [R05] terminal count decode ripples from top dibit down to bottom dibit
// [R06] pipeline flops plus load in the gate drop tc and load after one clock
// [R07] user must not preset tiny values; below ten for twenty bits
// [R08] bottom pipeline flop detects state one, so load comes from a flop
// [R09] load output is active low and forces all dibits into load
// [R10] below 30 MHz bottom dibit may match others; load excluded from its gate
// [R11] parallel outputs invalid while carries are pending; not for parallel reads
// [R12] most tc pipeline flops are optional and can be removed
// [R13] width in whole dibits up to forty bits; load presets every dibit
module ppdc_counter #(
    parameter SECTIONS = `PPDC_DEF_SECTIONS,
    parameter FAST_LSB = 1,
    parameter TC_PIPE = 1
) (
    input wire clk,                                          // counting clock, 50 MHz
    input wire rst,                                          // synchronous reset, high
    input wire [SECTIONS*`PPDC_SECTION_BITS-1:0] preset,     // reload value
    output wire [SECTIONS*`PPDC_SECTION_BITS-1:0] count,     // dibit states, see limits
    output reg parallel_load_enable_n,                       // load pulse, active low
    output reg terminal_count_flag                           // high in each load cycle except the one forced by reset
);

    localparam SB = `PPDC_SECTION_BITS;
    // carries run between dibits only; the top dibit's carry is dropped
    localparam CW = (SECTIONS > 1) ? SECTIONS - 1 : 1;

    // one decode shared by the load gate and the lsb carry
    function dibit_is;
        input [`PPDC_SECTION_BITS-1:0] v;
        input [`PPDC_SECTION_BITS-1:0] code;
        begin
            dibit_is = (v == code);
        end
    endfunction

    wire [CW-1:0] carry_chain;
    wire [SECTIONS:1] tc_into;

    reg [SB-1:0] lsb_bits;
    reg lsb_carry;
    reg [SB-1:0] next_lsb_bits;
    reg next_lsb_carry;
    reg next_load_n;
    reg next_flag;

    // top dibit sees an always-true terminal count from above
    assign tc_into[SECTIONS] = 1'b1;

    // lsb dibit lives here: its pipeline flop is the load flop itself
    // count is only meaningful once pending carries drain
    assign count[SB-1:0] = lsb_bits;                                 // [R11]
    assign carry_chain[0] = lsb_carry;                               // [R03]

    always @* begin
        next_lsb_bits = lsb_bits;
        next_lsb_carry = 1'b0;
        if (parallel_load_enable_n == `PPDC_LOAD_ACTIVE) begin
            next_lsb_bits = preset[SB-1:0];                          // [R09] [R13]
        end else begin
            next_lsb_bits = lsb_bits - `PPDC_DIBIT_STEP;              // [R01]
            next_lsb_carry = dibit_is(lsb_bits, `PPDC_DIBIT_ZERO);   // [R03] [R04]
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            lsb_bits <= `PPDC_RESET_COUNT;
            lsb_carry <= 1'b0;
        end else begin
            lsb_bits <= next_lsb_bits;
            lsb_carry <= next_lsb_carry;
        end
    end

    // upper dibits; tc_into[k] leaves dibit k toward dibit k-1
    genvar k;
    generate
        for (k = 1; k < SECTIONS; k = k + 1) begin : g_sec
            if (k < SECTIONS - 1) begin : g_mid
                ppdc_section #(
                    .TC_PIPE(TC_PIPE)
                ) u_sec (
                    .clk(clk),
                    .rst(rst),
                    .carry_in(carry_chain[k-1]),                     // [R03]
                    .load_n(parallel_load_enable_n),
                    .preset_bits(preset[k*SB +: SB]),
                    .tc_in(tc_into[k+1]),                            // [R05]
                    .count_bits(count[k*SB +: SB]),
                    .carry_out(carry_chain[k]),
                    .tc_out(tc_into[k])
                );
            end else begin : g_top
                // a load always comes before the top dibit could wrap
                ppdc_section #(
                    .TC_PIPE(TC_PIPE)
                ) u_sec (
                    .clk(clk),
                    .rst(rst),
                    .carry_in(carry_chain[k-1]),                     // [R03]
                    .load_n(parallel_load_enable_n),
                    .preset_bits(preset[k*SB +: SB]),
                    .tc_in(tc_into[k+1]),                            // [R05]
                    .count_bits(count[k*SB +: SB]),
                    .carry_out(),
                    .tc_out(tc_into[k])
                );
            end
        end
    endgenerate

    // the gate that builds the next load pulse
    always @* begin
        next_load_n = `PPDC_LOAD_IDLE;
        if (FAST_LSB != 0) begin
            // one state early so the load comes straight off a flop
            if (dibit_is(lsb_bits, `PPDC_DIBIT_ONE) && tc_into[1]
                    && (parallel_load_enable_n == `PPDC_LOAD_IDLE)) begin // [R08] [R06]
                next_load_n = `PPDC_LOAD_ACTIVE;
            end
        end else begin
            // slow variant: plain zero decode, load kept out of the gate
            if (dibit_is(lsb_bits, `PPDC_DIBIT_ZERO) && tc_into[1]) begin // [R10]
                next_load_n = `PPDC_LOAD_ACTIVE;
            end
        end
        next_flag = (next_load_n == `PPDC_LOAD_ACTIVE);
    end

    always @(posedge clk) begin
        if (rst) begin
            // load on the first edge after reset so the preset is taken
            parallel_load_enable_n <= `PPDC_LOAD_ACTIVE;
            terminal_count_flag <= 1'b0;
        end else begin
            parallel_load_enable_n <= next_load_n;                   // [R09]
            terminal_count_flag <= next_flag;                        // [R06]
        end
    end

endmodule // ppdc_counter

// ### verif/ppdc_sva.sv
// assertions for the pipelined down-counter
// assumes bind to ppdc_counter, legal presets only
module ppdc_sva #(parameter int SECTIONS = 20) (
    input wire clk, // clock
    input wire rst, // sync reset
    input wire [2*SECTIONS-1:0] preset, // reload
    input wire [2*SECTIONS-1:0] count, // dibits
    input wire parallel_load_enable_n, // load, low
    input wire terminal_count_flag // load flag
);
    wire ld_n = parallel_load_enable_n;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_load_one_cycle: assert property ($fell(ld_n) |=> ld_n)
        else $error("load too long");
    a_flag_inverse: assert property (!$past(rst) |-> terminal_count_flag == !ld_n)
        else $error("flag mismatch");
    a_load_presets: assert property (!ld_n |=> count == $past(preset))
        else $error("no reload");
    a_load_from_one: assert property (!ld_n && !$past(rst) |-> $past(count) == 1)
        else $error("early load");
    a_one_loads: assert property (ld_n && count == 1 |=> !ld_n)
        else $error("missed load");
    a_lsb_steps: assert property (ld_n |=> count[1:0] == $past(count[1:0]) - 2'h1)
        else $error("lsb not down");
    a_carry_once: assert property (ld_n && $past(ld_n) && count[1:0] == 2'h3 &&
        $past(count[1:0]) == 2'h0 |=> count[3:2] == $past(count[3:2]) - 2'h1)
        else $error("carry lost");
    a_reset_state: assert property (disable iff (1'b0) rst |=> count == '0 && !ld_n)
        else $error("bad reset");
    c_load: cover property ($fell(ld_n));
    c_wrap: cover property (count[1:0] == 2'h0 ##1 count[1:0] == 2'h3);
    c_reload: cover property (!ld_n ##1 ld_n);
endmodule // ppdc_sva

bind ppdc_counter ppdc_sva #(.SECTIONS(SECTIONS)) ppdc_sva_i (.clk(clk), .rst(rst),
    .preset(preset), .count(count), .parallel_load_enable_n(parallel_load_enable_n),
    .terminal_count_flag(terminal_count_flag));

// ### verif/tb_top.sv
// bench for the pipelined down-counter
// assumes four dibits and a 50 MHz clock
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] preset = 8'h10;
    wire [7:0] count;
    wire ld_n;
    wire tc;
    int errors = 0;
    int n_tests = 0;
    int gap;
    logic [7:0] pv [4] = '{8'h40, 8'hFF, 8'h0C, 8'h10}; // small presets avoided
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED %0t got %0h", $time, a); end end
    ppdc_counter #(.SECTIONS(4)) ppdc_counter_i (.clk(clk), .rst(rst), .preset(preset),
        .count(count), .parallel_load_enable_n(ld_n), .terminal_count_flag(tc));
    always #10 clk = ~clk;
    task automatic report_and_stop;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic run(input logic [7:0] p);
        rst = 1'b1;
        preset = p;
        repeat (4) @(negedge clk);
        `CHK(count, 8'h00)
        `CHK(ld_n, 1'b0)
        `CHK(tc, 1'b0)
        rst = 1'b0;
        @(negedge clk);
        for (int r = 0; r < 3; r++) begin
            `CHK(count, p)
            gap = 0;
            // bounded wait for the next load pulse
            while (ld_n === 1'b1 && gap < 300) begin
                `CHK(tc, 1'b0)
                gap++;
                @(negedge clk);
            end
            if (gap >= 300) begin
                errors++;
                $display("CHECK FAILED %0t no load pulse", $time);
                report_and_stop;
            end
            `CHK(gap, int'(p))
            `CHK(tc, 1'b1)
            @(negedge clk);
            `CHK(ld_n, 1'b1)
            `CHK(tc, 1'b0)
        end
    endtask
    initial begin
        foreach (pv[i])
            run(pv[i]);
        report_and_stop;
    end
endmodule // tb_top
